/* sfs_pkg.sv */
// Functional notes
// - opcode 06h in a complete frame sets write_latch_flag.
// - 50h arms a volatile status write without setting write_latch_flag.
// - opcode 04h in a complete frame clears write_latch_flag.
// - write_latch_flag clears after reset and when a non-volatile status write completes.
// - 05h returns status register 1, 35h register 2, even while busy.
// - single-lane status bits leave on falling edges, msb first.
// - quad command mode sends status bits 7:4 then 3:0 on four lanes.
// - status byte repeats while clocks run; chip select high ends it.
// - 01h changes only the writable protect bits of both registers.
// - status write executes only if frame ends after bit 8 or 16.
// - eight-bit 01h write clears protect_complement, quad_enable, protect_mode_bit1.
// - valid non-volatile write starts self-timed busy cycle; busy set clears write_latch_flag.
// - 31h needs write_latch_flag and updates only the register 2 writable bits.
// - 03h plus 24-bit address streams the byte out msb first, no dummies.
// - address increments after each byte until chip select rises.
// - a read issued while busy is ignored and leaves the cycle alone.
// - 0Bh latches address on rising edges, dummy clocks, then falling-edge data.
// - quad fast read dummies are 4, 6 or 8 from C0h, default 4.
// - 3Bh adds eight dummy clocks then sends data on two lanes.
// - dual data puts even bits on IO0 and odd bits on IO1.
// - quad address nibbles carry the highest bit on IO3, msb nibble first.
package sfs_pkg;
   // ************************************************************
   // command codes
   // ************************************************************
   localparam logic [7:0] OP_WR_ENABLE = 8'h06;
   localparam logic [7:0] OP_VOL_ENABLE = 8'h50;
   localparam logic [7:0] OP_WR_DISABLE = 8'h04;
   localparam logic [7:0] OP_RD_STAT1 = 8'h05;
   localparam logic [7:0] OP_RD_STAT2 = 8'h35;
   localparam logic [7:0] OP_WR_STAT = 8'h01;
   localparam logic [7:0] OP_WR_STAT2 = 8'h31;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_DUAL_READ = 8'h3B;
   localparam logic [7:0] OP_SET_PARAM = 8'hC0;
   // ************************************************************
   // status register layout
   // ************************************************************
   localparam logic [7:0] SR1_WR_MASK = 8'hFC; // protect bits 7:2
   localparam logic [7:0] SR2_WR_MASK = 8'h43; // complement, quad enable, protect 1
   localparam int SR1_CTL_LSB = 2;
   localparam logic [7:0] SR_ZERO = 8'h00;
   localparam int PARAM_LSB = 4; // dummy select sits in P[5:4]
   localparam logic [1:0] PARAM_RESET = 2'h0;
   // ************************************************************
   // link framing counts
   // ************************************************************
   localparam logic [4:0] OPC_LAST_SPI = 5'h07;
   localparam logic [4:0] OPC_LAST_QUAD = 5'h01;
   localparam logic [4:0] ADDR_LAST_SPI = 5'h17;
   localparam logic [4:0] ADDR_LAST_QUAD = 5'h05;
   localparam logic [4:0] DUMMY_SPI = 5'h08;
   localparam logic [4:0] DUMMY_Q4 = 5'h04;
   localparam logic [4:0] DUMMY_Q6 = 5'h06;
   localparam logic [4:0] DUMMY_Q8 = 5'h08;
   localparam logic [4:0] DIN_BITS_ONE = 5'h08;
   localparam logic [4:0] DIN_BITS_TWO = 5'h10;
   localparam logic [4:0] DIN_BITS_CAP = 5'h14;
   localparam logic [2:0] OUT_LAST_1 = 3'h7;
   localparam logic [2:0] OUT_LAST_2 = 3'h3;
   localparam logic [2:0] OUT_LAST_4 = 3'h1;
   localparam int MEM_AW = 8;
   localparam int MEM_DEPTH = 256;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int WSR_TIME_US = 5000; // plain default for the self-timed write
   localparam int WSR_CYCLES_DEF = (WSR_TIME_US * 1000) / CLK_PERIOD_NS;
   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0] {L_CMD, L_ADDR, L_DUMMY, L_OUT, L_DIN, L_IGNORE} sfs_link_t;
   typedef enum logic [1:0] {LANE_1, LANE_2, LANE_4} sfs_lane_t;
endpackage : sfs_pkg

/* sfs_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_sync2 #(
   parameter int W = 1
) (
   clk,
   d,
   q
);
   input wire logic clk;
   input wire logic [W-1:0] d;
   output logic [W-1:0] q;
   logic [W-1:0] meta_reg;
   // ************************************************************
   // two-stage level synchroniser
   // ************************************************************
   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      meta_reg <= d;
      q <= meta_reg;
   end
endmodule : sfs_sync2
`default_nettype wire

/* sfs_wr_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_wr_timer #(
   parameter int unsigned CYCLES = 100
) (
   clk,
   reset,
   start,
   busy,
   done
);
   input wire logic clk;
   input wire logic reset;
   input wire logic start;
   output logic busy;
   output logic done;
   logic [31:0] cnt_reg;
   // ************************************************************
   // self-timed write cycle
   // ************************************************************
   // start while busy is ignored; the caller never issues one
   always_ff @(posedge clk) begin
      if (reset) begin
         busy <= 1'b0;
         done <= 1'b0;
         cnt_reg <= 32'h0000_0000;
      end else if (start && !busy) begin
         busy <= 1'b1;
         done <= 1'b0;
         cnt_reg <= CYCLES - 32'h0000_0001;
      end else if (busy && cnt_reg == 32'h0000_0000) begin
         busy <= 1'b0;
         done <= 1'b1;
      end else begin
         done <= 1'b0;
         cnt_reg <= busy ? cnt_reg - 32'h0000_0001 : cnt_reg;
      end
   end
endmodule : sfs_wr_timer
`default_nettype wire

/* sfs_flash_cmd.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_flash_cmd #(
   parameter int unsigned WSR_CYCLES = sfs_pkg::WSR_CYCLES_DEF
) (
   clk,
   reset,
   sclk,
   csN,
   ioIn,
   ioOut,
   ioOe,
   quadCmdMode,
   loadEn,
   loadAddr,
   loadData,
   statusReg1,
   statusReg2
);
   import sfs_pkg::*;
   input wire logic clk;
   input wire logic reset;
   input wire logic sclk;
   input wire logic csN;
   input wire logic [3:0] ioIn;
   output logic [3:0] ioOut;
   output logic [3:0] ioOe;
   input wire logic quadCmdMode;
   input wire logic loadEn;
   input wire logic [sfs_pkg::MEM_AW-1:0] loadAddr;
   input wire logic [7:0] loadData;
   output logic [7:0] statusReg1;
   output logic [7:0] statusReg2;

   // ************************************************************
   // declarations
   // ************************************************************
   // system clock domain
   logic linkRst_reg;
   logic csD1_reg;
   logic csD2_reg;
   logic seenTog_reg;
   logic wel_reg;
   logic volArm_reg;
   logic [5:0] sr1Ctl_reg;
   logic [7:0] sr2Ctl_reg;
   logic [1:0] readParam_reg;
   logic qcmMode_reg;
   logic [1:0] clkSync;
   logic busy;
   logic wsrDone;
   // link clock domain
   sfs_link_t linkState_reg;
   sfs_link_t linkState_next;
   sfs_lane_t outLanes_reg;
   logic [4:0] phaseCnt_reg;
   logic [7:0] shiftIn_reg;
   logic [7:0] curOp_reg;
   logic [23:0] addr_reg;
   logic [7:0] recOp_reg;
   logic [15:0] recData_reg;
   logic [4:0] recBits_reg;
   logic recTog_reg;
   logic [16:0] linkSync;
   logic [7:0] outSh_reg;
   logic [2:0] outCnt_reg;
   logic [23:0] byteIdx_reg;
   logic [7:0] memArr [MEM_DEPTH];

   // ************************************************************
   // array preload port
   // ************************************************************
   // program and erase are outside this block, so contents arrive here
   always_ff @(posedge clk) begin
      if (loadEn) begin
         memArr[loadAddr] <= loadData;
      end
   end

   // ************************************************************
   // crossings into the system clock
   // ************************************************************
   sfs_sync2 #(
      .W(2)
   ) u_clk_sync (
      .clk(clk),
      .d({recTog_reg, csN}),
      .q(clkSync)
   );

   // frame ends one cycle after the synchronised rise, so the toggle has landed
   wire csS = clkSync[0];
   wire togS = clkSync[1];
   wire frameEnd = csS && csD1_reg && !csD2_reg;
   wire exec = frameEnd && (togS != seenTog_reg) && !busy;

   // cs edge pipeline and a registered copy of reset for the link side
   always_ff @(posedge clk) begin
      csD1_reg <= reset ? 1'b1 : csS;
      csD2_reg <= reset ? 1'b1 : csD1_reg;
      linkRst_reg <= reset;
   end

   // ************************************************************
   // command decode at frame end
   // ************************************************************
   // records are stable here: sclk is still while cs is high
   wire isWrEn = recOp_reg == OP_WR_ENABLE;
   wire isWrDis = recOp_reg == OP_WR_DISABLE;
   wire isVol = recOp_reg == OP_VOL_ENABLE;
   wire isWsr = recOp_reg == OP_WR_STAT;
   wire isWsr2 = recOp_reg == OP_WR_STAT2;
   wire isParam = recOp_reg == OP_SET_PARAM;
   wire bitsOne = recBits_reg == DIN_BITS_ONE;
   wire bitsTwo = recBits_reg == DIN_BITS_TWO;
   wire [7:0] firstByte = bitsTwo ? recData_reg[15:8] : recData_reg[7:0];
   wire [7:0] secondByte = recData_reg[7:0];
   wire wrAllowed = wel_reg || volArm_reg;
   wire wsrOk = exec && isWsr && wrAllowed && (bitsOne || bitsTwo);
   wire wsr2Ok = exec && isWsr2 && wel_reg && bitsOne;
   wire nvStart = (wsrOk || wsr2Ok) && !volArm_reg;
   wire paramOk = exec && isParam && (bitsOne || bitsTwo);

   // toggle bookkeeping and the volatile arm
   always_ff @(posedge clk) begin
      if (reset) begin
         seenTog_reg <= 1'b0;
         volArm_reg <= 1'b0;
      end else begin
         seenTog_reg <= frameEnd ? togS : seenTog_reg;
         // arm lasts for exactly the next command
         volArm_reg <= exec ? isVol : volArm_reg;
      end
   end

   // write latch: a 06h landing on the done cycle wins over the done clear
   always_ff @(posedge clk) begin
      if (reset) begin
         wel_reg <= 1'b0;
      end else if (exec && isWrEn) begin
         wel_reg <= 1'b1;
      end else if (nvStart || wsrDone) begin
         wel_reg <= 1'b0;
      end else if (exec && isWrDis) begin
         wel_reg <= 1'b0;
      end
   end

   // writable protect fields; values take effect as the cycle starts
   always_ff @(posedge clk) begin
      if (reset) begin
         sr1Ctl_reg <= SR_ZERO[7:SR1_CTL_LSB];
         sr2Ctl_reg <= SR_ZERO;
      end else if (wsrOk) begin
         sr1Ctl_reg <= firstByte[7:SR1_CTL_LSB];
         sr2Ctl_reg <= bitsTwo ? (secondByte & SR2_WR_MASK) : SR_ZERO;
      end else if (wsr2Ok) begin
         sr2Ctl_reg <= secondByte & SR2_WR_MASK;
      end
   end

   // read parameters and the quad mode copy change only between frames
   always_ff @(posedge clk) begin
      if (reset) begin
         readParam_reg <= PARAM_RESET;
         qcmMode_reg <= 1'b0;
      end else begin
         readParam_reg <= paramOk ? firstByte[PARAM_LSB+1:PARAM_LSB] : readParam_reg;
         qcmMode_reg <= (csS && csD1_reg) ? quadCmdMode : qcmMode_reg;
      end
   end

   // volatile writes skip the timed cycle entirely
   sfs_wr_timer #(
      .CYCLES(WSR_CYCLES)
   ) u_wr_timer (
      .clk(clk),
      .reset(reset),
      .start(nvStart),
      .busy(busy),
      .done(wsrDone)
   );

   // status images, built from flip-flops only
   assign statusReg1 = {sr1Ctl_reg, wel_reg, busy};
   assign statusReg2 = sr2Ctl_reg;

   // ************************************************************
   // crossings into the link clock
   // ************************************************************
   // stages refill on a frame's first two edges; busy is judged at address end
   sfs_sync2 #(
      .W(17)
   ) u_link_sync (
      .clk(sclk),
      .d({busy, statusReg1, statusReg2}),
      .q(linkSync)
   );

   wire busyL = linkSync[16];
   wire [7:0] sr1L = linkSync[15:8];
   wire [7:0] sr2L = linkSync[7:0];
   // quasi-static: only updated while cs is high and sclk is still
   wire quadIn = qcmMode_reg;

   // ************************************************************
   // link receive decode
   // ************************************************************
   wire [7:0] nextShift = quadIn ? {shiftIn_reg[3:0], ioIn} : {shiftIn_reg[6:0], ioIn[0]};
   wire opLast = phaseCnt_reg == (quadIn ? OPC_LAST_QUAD : OPC_LAST_SPI);
   wire addrLast = phaseCnt_reg == (quadIn ? ADDR_LAST_QUAD : ADDR_LAST_SPI);
   // highest address bit rides IO3 in each nibble
   wire [23:0] addrNext = quadIn ? {addr_reg[19:0], ioIn} : {addr_reg[22:0], ioIn[0]};
   wire opRead = (nextShift == OP_READ) && !quadIn;
   wire opFast = nextShift == OP_FAST_READ;
   wire opDual = (nextShift == OP_DUAL_READ) && !quadIn;
   wire opStat = (nextShift == OP_RD_STAT1) || (nextShift == OP_RD_STAT2);
   wire opDin = (nextShift == OP_WR_STAT) || (nextShift == OP_WR_STAT2)
      || (nextShift == OP_SET_PARAM);
   wire anyRead = opRead || opFast || opDual;
   wire [4:0] dummyQuad = (readParam_reg == 2'h0) ? DUMMY_Q4
      : (readParam_reg == 2'h1) ? DUMMY_Q6 : DUMMY_Q8;
   wire [4:0] dummyLen = (quadIn && curOp_reg == OP_FAST_READ) ? dummyQuad : DUMMY_SPI;
   wire dummyLast = phaseCnt_reg == dummyLen - 5'h01;
   wire curNoDummy = curOp_reg == OP_READ;

   // next link state
   always_comb begin
      linkState_next = linkState_reg;
      case (linkState_reg)
         L_CMD: begin
            if (opLast) begin
               if (anyRead) begin
                  linkState_next = L_ADDR;
               end else if (opStat) begin
                  linkState_next = L_OUT;
               end else if (opDin) begin
                  linkState_next = L_DIN;
               end else begin
                  linkState_next = L_IGNORE;
               end
            end
         end
         L_ADDR: begin
            if (addrLast && busyL) begin
               linkState_next = L_IGNORE;
            end else if (addrLast) begin
               linkState_next = curNoDummy ? L_OUT : L_DUMMY;
            end
         end
         L_DUMMY: begin
            linkState_next = dummyLast ? L_OUT : L_DUMMY;
         end
         default: begin
            linkState_next = linkState_reg;
         end
      endcase
   end

   // phase counter restarts on each state change; cs high clears the frame
   wire phaseWrap = linkState_next != linkState_reg;
   always_ff @(posedge sclk or posedge csN) begin
      if (csN) begin
         linkState_reg <= L_CMD;
         phaseCnt_reg <= 5'h00;
         shiftIn_reg <= 8'h00;
         curOp_reg <= 8'h00;
         addr_reg <= 24'h00_0000;
      end else begin
         linkState_reg <= linkState_next;
         phaseCnt_reg <= phaseWrap ? 5'h00 : phaseCnt_reg + 5'h01;
         shiftIn_reg <= (linkState_reg == L_CMD) ? nextShift : shiftIn_reg;
         curOp_reg <= (linkState_reg == L_CMD && opLast) ? nextShift : curOp_reg;
         addr_reg <= (linkState_reg == L_ADDR) ? addrNext : addr_reg;
      end
   end

   // output lane width is fixed once the opcode is known
   always_ff @(posedge sclk or posedge csN) begin
      if (csN) begin
         outLanes_reg <= LANE_1;
      end else if (linkState_reg == L_CMD && opLast) begin
         outLanes_reg <= opDual ? LANE_2 : (quadIn ? LANE_4 : LANE_1);
      end
   end

   // ************************************************************
   // frame record for the system side
   // ************************************************************
   // kept across cs so the system clock can read it after the frame ends
   wire [4:0] dinStep = quadIn ? 5'h04 : 5'h01;
   wire [15:0] dinNext = quadIn ? {recData_reg[11:0], ioIn} : {recData_reg[14:0], ioIn[0]};
   always_ff @(posedge sclk or posedge linkRst_reg) begin
      if (linkRst_reg) begin
         recTog_reg <= 1'b0;
         recOp_reg <= 8'h00;
         recData_reg <= 16'h0000;
         recBits_reg <= 5'h00;
      end else if (linkState_reg == L_CMD && opLast) begin
         recTog_reg <= ~recTog_reg;
         recOp_reg <= nextShift;
         recBits_reg <= 5'h00;
      end else if (linkState_reg == L_DIN) begin
         recData_reg <= dinNext;
         // saturates past sixteen so an overlong frame never matches
         recBits_reg <= (recBits_reg < DIN_BITS_CAP) ? recBits_reg + dinStep : recBits_reg;
      end
   end

   // ************************************************************
   // link transmit on falling edges
   // ************************************************************
   wire isStatOut = (curOp_reg == OP_RD_STAT1) || (curOp_reg == OP_RD_STAT2);
   wire [23:0] rdAddr = addr_reg + byteIdx_reg;
   wire [7:0] memByte = memArr[rdAddr[MEM_AW-1:0]];
   wire [7:0] statByte = (curOp_reg == OP_RD_STAT2) ? sr2L : sr1L;
   wire [7:0] srcByte = isStatOut ? statByte : memByte;
   wire loadByte = outCnt_reg == 3'h0;
   wire [7:0] curByte = loadByte ? srcByte : outSh_reg;
   wire [2:0] outLast = (outLanes_reg == LANE_4) ? OUT_LAST_4
      : (outLanes_reg == LANE_2) ? OUT_LAST_2 : OUT_LAST_1;
   // single lane drives IO1; dual puts odd bits on IO1, even on IO0
   wire [3:0] laneOut = (outLanes_reg == LANE_4) ? curByte[7:4]
      : (outLanes_reg == LANE_2) ? {2'b00, curByte[7], curByte[6]}
      : {2'b00, curByte[7], 1'b0};
   wire [3:0] laneOe = (outLanes_reg == LANE_4) ? 4'hF
      : (outLanes_reg == LANE_2) ? 4'h3 : 4'h2;
   wire [7:0] shNext = (outLanes_reg == LANE_4) ? {curByte[3:0], 4'h0}
      : (outLanes_reg == LANE_2) ? {curByte[5:0], 2'b00} : {curByte[6:0], 1'b0};

   // pins stay released through dummy clocks and on ignored frames
   always_ff @(negedge sclk or posedge csN) begin
      if (csN) begin
         ioOut <= 4'h0;
         ioOe <= 4'h0;
         outSh_reg <= 8'h00;
         outCnt_reg <= 3'h0;
         byteIdx_reg <= 24'h00_0000;
      end else if (linkState_reg == L_OUT) begin
         ioOut <= laneOut;
         ioOe <= laneOe;
         outSh_reg <= shNext;
         outCnt_reg <= loadByte ? outLast : outCnt_reg - 3'h1;
         // status bytes repeat; array reads advance one byte at a time
         byteIdx_reg <= (loadByte && !isStatOut) ? byteIdx_reg + 24'h00_0001 : byteIdx_reg;
      end else begin
         ioOut <= 4'h0;
         ioOe <= 4'h0;
      end
   end
endmodule : sfs_flash_cmd
`default_nettype wire

/* sfs_flash_cmd_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks for the flash command block
// ****
module sfs_flash_cmd_chk #(
   parameter int unsigned WSR_CYCLES = 200
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic csN,
   input wire logic [3:0] ioIn,
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOe,
   input wire logic quadCmdMode,
   input wire logic loadEn,
   input wire logic [sfs_pkg::MEM_AW-1:0] loadAddr,
   input wire logic [7:0] loadData,
   input wire logic [7:0] statusReg1,
   input wire logic [7:0] statusReg2
);
   import sfs_pkg::*;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   logic [15:0] busyCnt_reg;
   logic [15:0] busyCnt_next;
   // length of the running busy spell; a stuck timer shows here
   assign busyCnt_next = statusReg1[0] ? busyCnt_reg + 16'h0001 : 16'h0000;
   always_ff @(posedge clk) begin
      if (reset) busyCnt_reg <= 16'h0000;
      else busyCnt_reg <= busyCnt_next;
   end
   // lane drive
   idle_oe_a: assert property (csN |-> ioOe == 4'h0)
      else $error("lanes driven while deselected");
   spi_lanes_a: assert property (!quadCmdMode && ioOe != 4'h0 |-> ioOe inside {4'h2, 4'h3})
      else $error("single mode output on wrong lanes");
   quad_lanes_a: assert property (quadCmdMode && ioOe != 4'h0 |-> ioOe == 4'hF)
      else $error("quad output not on four lanes");
   // status register behaviour
   reset_clear_a: assert property (disable iff (1'b0)
      reset |=> statusReg1 == 8'h00 && statusReg2 == 8'h00)
      else $error("status not cleared by reset");
   sr2_fixed_a: assert property ((statusReg2 & 8'hBC) == 8'h00)
      else $error("read only bit of register 2 set");
   ctl_frame_a: assert property ($changed(statusReg1[7:2]) |-> csN)
      else $error("protect bits changed inside a frame");
   busy_wel_a: assert property ($rose(statusReg1[0]) |-> ##[0:1] !statusReg1[1])
      else $error("write latch kept after busy start");
   busy_start_a: assert property ($rose(statusReg1[0]) |-> csN && $past(csN) && $past(csN, 2))
      else $error("busy started before frame end");
   busy_hold_a: assert property ($rose(statusReg1[0]) |-> statusReg1[0] [*8])
      else $error("busy cycle cut short");
   busy_max_a: assert property (busyCnt_reg <= WSR_CYCLES + 2)
      else $error("busy cycle too long");
   busy_c: cover property ($rose(statusReg1[0]));
   quad_c: cover property (ioOe == 4'hF);
   dual_c: cover property (ioOe == 4'h3);
endmodule : sfs_flash_cmd_chk
bind sfs_flash_cmd sfs_flash_cmd_chk #(.WSR_CYCLES(WSR_CYCLES)) i_sfs_flash_cmd_chk (
   .clk(clk), .reset(reset), .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut),
   .ioOe(ioOe), .quadCmdMode(quadCmdMode), .loadEn(loadEn), .loadAddr(loadAddr),
   .loadData(loadData), .statusReg1(statusReg1), .statusReg2(statusReg2)
);
`default_nettype wire

/* sfs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// host controller, mode 0, link clock 32 ns
// ****
module sfs_host_model (
   output logic sclk,
   output logic csN,
   output logic [3:0] ioIn,
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOe
);
   logic [3:0] hostDrv = 4'h0;
   logic [3:0] got;
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
   end
   // pin level: whoever enables a lane owns it
   assign ioIn = (ioOe & ioOut) | (~ioOe & hostDrv);
   // released lanes toggle so a stale level never reads as data
   task automatic tick(input logic [3:0] v, input logic [3:0] m);
      hostDrv = (m & v) | (~m & ~hostDrv);
      #16 sclk = 1'b1;
      got = ioIn;
      #16 sclk = 1'b0;
   endtask : tick
   task automatic put(input logic [7:0] b, input int w);
      for (int i = 8 - w; i >= 0; i -= w) begin
         tick(w == 4 ? b[i+:4] : {3'b000, b[i]}, w == 4 ? 4'hF : 4'h1);
      end
   endtask : put
   task automatic put_addr(input logic [23:0] a, input int w);
      put(a[23:16], w);
      put(a[15:8], w);
      put(a[7:0], w);
   endtask : put_addr
   task automatic get(output logic [7:0] b, input int w);
      b = 8'h00;
      for (int i = 0; i < 8; i += w) begin
         tick(4'h0, 4'h0);
         b = w == 4 ? {b[3:0], got} : w == 2 ? {b[5:0], got[1:0]} : {b[6:0], got[1]};
      end
   endtask : get
   task automatic idle(input int n);
      repeat (n) tick(4'h0, 4'h0);
   endtask : idle
   task automatic start(input logic [7:0] c, input int w);
      csN = 1'b0;
      #16;
      put(c, w);
   endtask : start
   // deselect right after the last whole unit, then a long gap
   task automatic stop;
      #16 csN = 1'b1;
      #400;
   endtask : stop
endmodule : sfs_host_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sfs_pkg::*;
   localparam int unsigned WSR = 200;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic quadCmdMode = 1'b0;
   logic loadEn = 1'b0;
   logic [MEM_AW-1:0] loadAddr = 8'h00;
   logic [7:0] loadData = 8'h00;
   wire logic sclk;
   wire logic csN;
   wire logic [3:0] ioIn;
   wire logic [3:0] ioOut;
   wire logic [3:0] ioOe;
   wire logic [7:0] statusReg1;
   wire logic [7:0] statusReg2;
   logic [7:0] rd;
   logic [7:0] pat [3] = '{8'hA5, 8'h3C, 8'h0F};
   int failures = 0;
   int n_tests = 0;
   int oeHits = 0;
   // ****
   // clock, device and host
   // ****
   always #25 clk = ~clk;
   always @(posedge sclk) if (|ioOe) oeHits++;
   sfs_flash_cmd #(.WSR_CYCLES(WSR)) i_sfs_flash_cmd (
      .clk(clk), .reset(reset), .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut),
      .ioOe(ioOe), .quadCmdMode(quadCmdMode), .loadEn(loadEn), .loadAddr(loadAddr),
      .loadData(loadData), .statusReg1(statusReg1), .statusReg2(statusReg2));
   sfs_host_model i_sfs_host_model (
      .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
   task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask : cmp
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run
   // frame helpers; lane count follows the command mode
   task automatic cmd(input logic [7:0] c);
      i_sfs_host_model.start(c, quadCmdMode ? 4 : 1);
      i_sfs_host_model.stop();
   endtask : cmd
   task automatic wsr(input logic [7:0] c, input logic [15:0] d, input int n);
      i_sfs_host_model.start(c, quadCmdMode ? 4 : 1);
      i_sfs_host_model.put(d[15:8], quadCmdMode ? 4 : 1);
      if (n == 16) i_sfs_host_model.put(d[7:0], quadCmdMode ? 4 : 1);
      if (n == 12) i_sfs_host_model.idle(4);
      i_sfs_host_model.stop();
   endtask : wsr
   task automatic get_chk(input string what, input int w, input logic [7:0] e);
      i_sfs_host_model.get(rd, w);
      cmp(what, e, rd);
   endtask : get_chk
   task automatic rd_frame(input logic [7:0] c, input int dw, input int nd, input int k,
                           input int n);
      i_sfs_host_model.start(c, quadCmdMode ? 4 : 1);
      i_sfs_host_model.put_addr(24'h00_000A + 24'(k), quadCmdMode ? 4 : 1);
      i_sfs_host_model.idle(nd);
      for (int i = k; i < k + n; i++) get_chk("read data", dw, pat[i]);
      i_sfs_host_model.stop();
   endtask : rd_frame
   // bounded wait; the status compare that follows judges the outcome
   task automatic wait_idle;
      for (int i = 0; i < 400 && statusReg1[0] !== 1'b0; i++) @(negedge clk);
   endtask : wait_idle
   // ****
   // scenarios
   // ****
   task automatic s_latch;
      cmd(OP_WR_ENABLE);
      cmp("wel set", 8'h02, statusReg1);
      i_sfs_host_model.start(OP_RD_STAT1, 1);
      get_chk("sr1 link", 1, 8'h02);
      get_chk("sr1 repeat", 1, 8'h02);
      i_sfs_host_model.stop();
      i_sfs_host_model.start(OP_RD_STAT2, 1);
      get_chk("sr2 link", 1, 8'h00);
      i_sfs_host_model.stop();
      cmd(OP_WR_DISABLE);
      cmp("wel clear", 8'h00, statusReg1);
      wsr(OP_WR_STAT, 16'hFFFF, 16);
      cmp("no latch", 8'h00, statusReg1);
      cmd(OP_WR_ENABLE);
      wsr(OP_WR_STAT, 16'hFFFF, 12);
      cmp("odd count", 8'h02, statusReg1);
      cmd(OP_WR_DISABLE);
      cmd(OP_VOL_ENABLE);
      wsr(OP_WR_STAT, 16'h1C02, 16);
      cmp("volatile sr1", 8'h1C, statusReg1);
      cmp("volatile sr2", 8'h02, statusReg2);
   endtask : s_latch
   task automatic s_write;
      int n;
      cmd(OP_WR_ENABLE);
      wsr(OP_WR_STAT, 16'hFFFF, 16);
      cmp("sr1 busy", 8'hFD, statusReg1);
      cmp("sr2 mask", 8'h43, statusReg2);
      i_sfs_host_model.start(OP_RD_STAT1, 1);
      get_chk("busy read", 1, 8'hFD);
      i_sfs_host_model.stop();
      n = oeHits;
      rd_frame(OP_READ, 1, 8, 0, 0);
      cmp("read while busy", 8'(n), 8'(oeHits));
      wait_idle();
      cmp("write done", 8'hFC, statusReg1);
      cmd(OP_WR_ENABLE);
      wsr(OP_WR_STAT, 16'h0000, 8);
      cmp("short write", 8'h00, statusReg2);
      wait_idle();
      cmd(OP_WR_ENABLE);
      wsr(OP_WR_STAT2, 16'hFF00, 8);
      cmp("sr2 write sr1", 8'h01, statusReg1);
      cmp("sr2 write", 8'h43, statusReg2);
      wait_idle();
   endtask : s_write
   task automatic s_reads;
      for (int i = 0; i < 3; i++) begin
         @(negedge clk);
         loadEn = 1'b1;
         loadAddr = 8'(10 + i);
         loadData = pat[i];
      end
      @(negedge clk);
      loadEn = 1'b0;
      rd_frame(OP_READ, 1, 0, 0, 3);
      rd_frame(OP_FAST_READ, 1, 8, 1, 2);
      rd_frame(OP_DUAL_READ, 2, 8, 0, 3);
   endtask : s_reads
   task automatic s_quad;
      @(negedge clk);
      quadCmdMode = 1'b1;
      #200;
      cmd(OP_WR_ENABLE);
      i_sfs_host_model.start(OP_RD_STAT1, 4);
      get_chk("quad sr1", 4, 8'h02);
      i_sfs_host_model.stop();
      for (int k = 0; k < 3; k++) begin
         if (k > 0) wsr(OP_SET_PARAM, {8'(k << 4), 8'h00}, 8);
         rd_frame(OP_FAST_READ, 4, 4 + 2 * k, k, 1);
      end
   endtask : s_quad
   initial begin
      repeat (8) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      s_latch();
      s_write();
      s_reads();
      s_quad();
      complete_run();
   end
   // watchdog well beyond the expected run of under 100 us
   initial begin
      #300000;
      failures++;
      complete_run();
   end
endmodule : testbench
`default_nettype wire
